// ### sim/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire       clock,
  input  wire [7:0] reg_rdata_ff,
  output reg        reg_wr = 1'b0,
  output reg        reg_rd = 1'b0,
  output reg  [7:0] reg_addr = 8'h00,
  output reg  [7:0] reg_wdata = 8'h00
);
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == 8'h69 && d[7]) ? (d & 8'hfe) : d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~reg_wdata;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_ff;
  endtask
endmodule

// ### sim/sensor_path_regs_chk.sv
`timescale 1ns/1ps
module sensor_path_regs_chk (
  input wire       clock,
  input wire       nrst,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_ff,
  input wire       queue_src_write,
  input wire       queue_write_ff,
  input wire       queue_host_access_ff,
  input wire       queue_reset_n_ff,
  input wire       two_wire_enable_ff,
  input wire       motion_detect_active_ff,
  input wire       accel_path_reset_ff,
  input wire       temp_path_reset_ff,
  input wire       gyro_path_reset_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire w6a = reg_wr && reg_addr == 8'h6a;
  wire w68 = reg_wr && reg_addr == 8'h68;
  property p_all; w6a && reg_wdata[0] |-> ##2 gyro_path_reset_ff && accel_path_reset_ff && temp_path_reset_ff; endproperty
  property p_acc; w68 && reg_wdata[1] |-> ##2 accel_path_reset_ff; endproperty
  property p_tmp; w68 && reg_wdata[0] |-> ##2 temp_path_reset_ff; endproperty
  property p_one; $rose(gyro_path_reset_ff) |=> !gyro_path_reset_ff; endproperty
  property p_qwr; queue_write_ff == $past(queue_src_write); endproperty
  property p_qacc; w6a |-> ##[1:3] queue_host_access_ff == $past(reg_wdata[6], 2); endproperty
  property p_twd; w6a && reg_wdata[4] |-> ##[1:3] !two_wire_enable_ff; endproperty
  property p_qrst; w6a && reg_wdata[2] |-> ##[1:3] !queue_reset_n_ff; endproperty
  property p_mot; reg_wr && reg_addr == 8'h69 && reg_wdata[7] |-> ##[1:4] motion_detect_active_ff; endproperty
  property p_unm; reg_rd && reg_addr == 8'h00 |=> reg_rdata_ff == 8'h00; endproperty
  a_all: assert property (p_all) else $error("combined reset pulses missing");
  a_acc: assert property (p_acc) else $error("accel path reset missing");
  a_tmp: assert property (p_tmp) else $error("temp path reset missing");
  a_one: assert property (p_one) else $error("path reset pulse too long");
  a_qwr: assert property (p_qwr) else $error("queue write not passed");
  a_qacc: assert property (p_qacc) else $error("queue access wrong");
  a_twd: assert property (p_twd) else $error("two wire not disabled");
  a_qrst: assert property (p_qrst) else $error("queue reset missing");
  a_mot: assert property (p_mot) else $error("motion detect not active");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  c_qrst: cover property (!queue_reset_n_ff ##1 queue_reset_n_ff);
  c_all: cover property (gyro_path_reset_ff);
  c_mot: cover property (motion_detect_active_ff);
endmodule
bind sensor_path_regs sensor_path_regs_chk i_chk (.*);

// ### sim/tb_sensor_path_regs.sv
`timescale 1ns/1ps
module tb_sensor_path_regs;
  reg         clock = 1'b0, nrst = 1'b0, sample_valid = 1'b0, osc_tick = 1'b0, queue_src_write = 1'b0;
  reg  [15:0] temp_sample = 16'h0000, rate_x_sample = 16'h0000, rate_y_sample = 16'h0000, rate_z_sample = 16'h0000;
  wire        reg_wr, reg_rd, queue_write_ff, queue_host_access_ff, queue_reset_n_ff, two_wire_enable_ff;
  wire        motion_detect_active_ff, motion_compare_mode_ff, accel_path_reset_ff, temp_path_reset_ff;
  wire        gyro_path_reset_ff;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata_ff;
  reg  [7:0]  d, a;
  reg  [63:0] e;
  int         mismatches = 0, n_checks = 0, i;
  always #5 clock = ~clock;
  sensor_path_regs i_dut (.*);
  host_model i_host (.*);
  task complete_run;
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input [7:0] x, input [7:0] g);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task results(input [63:0] x);
    for (a = 8'h41; a < 8'h49; a++) begin
      i_host.rd(a, d);
      e = x >> (8 * (8'h48 - a));
      chk("result", e[7:0], d);
    end
  endtask
  task s_results;
    @(posedge clock);
    temp_sample <= 16'h1234;
    rate_x_sample <= 16'd131 * 2;
    rate_y_sample <= -(16'd131 * 5);
    rate_z_sample <= 16'd131 * 100;
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    i_host.wr(8'h43, 8'haa);
    i_host.wr(8'h68, 8'h03);
    results({16'h1234, 16'd262, 16'hfd71, 16'd13100});
    i_host.rd(8'h00, d);
    chk("unmapped", 8'h00, d);
  endtask
  task s_host;
    i_host.wr(8'h6a, 8'hf0);
    i_host.rd(8'h6a, d);
    chk("host_control", 8'h50, d);
    chk("two_wire", 8'h00, two_wire_enable_ff);
    i_host.wr(8'h6a, 8'h00);
    repeat (3) @(posedge clock);
    chk("queue_access", 8'h00, queue_host_access_ff);
    queue_src_write <= 1'b1;
    repeat (2) @(posedge clock);
    queue_src_write <= 1'b0;
    chk("queue_write", 8'h01, queue_write_ff);
  endtask
  task s_qreset;
    i_host.wr(8'h6a, 8'h04);
    i_host.rd(8'h6a, d);
    chk("queue_rst_bit", 8'h04, d);
    chk("queue_rst_n", 8'h00, queue_reset_n_ff);
    osc_tick <= 1'b1;
    repeat (4) @(posedge clock);
    osc_tick <= 1'b0;
    for (i = 0; i < 20 && queue_reset_n_ff !== 1'b1; i++) @(posedge clock);
    if (i == 20) begin
      mismatches++;
      complete_run;
    end
    i_host.rd(8'h6a, d);
    chk("queue_rst_clear", 8'h00, d);
  endtask
  task s_motion;
    i_host.wr(8'h69, 8'hff);
    i_host.rd(8'h69, d);
    chk("motion_ctrl", 8'hc0, d);
    repeat (3) @(posedge clock);
    chk("motion_on", 8'h01, {motion_detect_active_ff});
    chk("compare_mode", 8'h01, {motion_compare_mode_ff});
    i_host.wr(8'h69, 8'h00);
    repeat (4) @(posedge clock);
    chk("motion_off", 8'h00, {motion_detect_active_ff});
    chk("compare_first", 8'h00, {motion_compare_mode_ff});
  endtask
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    s_results;
    s_host;
    s_qreset;
    s_motion;
    i_host.wr(8'h6a, 8'h01);
    repeat (3) @(posedge clock);
    results(64'h0);
    complete_run;
  end
endmodule

// ### src/pulse_stretch.v
`timescale 1ns/1ps
// Holds a pulse high until the slow clock enable has been seen once
module pulse_stretch (
  input  wire clock,
  input  wire nrst,
  input  wire start,
  input  wire slow_tick,
  output reg  busy_ff
);
  reg nxt_busy;
  always @* begin
    nxt_busy = busy_ff;
    if (start) begin
      nxt_busy = 1'b1;
    end else if (slow_tick) begin
      nxt_busy = 1'b0;
    end
  end
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
    end
  end
endmodule

// ### src/sensor_path_regs.v
`timescale 1ns/1ps
`include "sensor_regs_consts.vh"
// What this block does
// - Temperature result read as high byte at 0x41, low byte at 0x42
// - X rate result read as high byte at 0x43, low byte at 0x44
// - Y rate result read as high byte at 0x45, low byte at 0x46
// - Z rate result read as high byte at 0x47, low byte at 0x48
// - Rate result is sensitivity times rate, 131 counts per dps at scale zero
// - Path reset bit 1 resets accelerometer path, results kept
// - Path reset bit 0 resets temperature path, results kept
// - Motion control bit 7 enables wake-on-motion detector
// - Compare mode picks first sample or previous sample as reference
// - Host control bit 6 enables queue, else serial queue access blocked
// - Queue operation bit never stops internal queue writes
// - Host control bit 4 disables two-wire slave, four-wire only
// - Host control bit 2 resets queue module asynchronously
// - Queue reset bit self-clears after one internal 20 MHz cycle
// - Host control bit 0 resets gyro, accel and temp paths together
// - Combined reset also clears all sensor result registers
module sensor_path_regs (
  input  wire        clock,
  input  wire        nrst,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata_ff,
  input  wire        sample_valid,
  input  wire [15:0] temp_sample,
  input  wire [15:0] rate_x_sample,
  input  wire [15:0] rate_y_sample,
  input  wire [15:0] rate_z_sample,
  input  wire        osc_tick,
  input  wire        queue_src_write,
  output reg         queue_write_ff,
  output reg         queue_host_access_ff,
  output reg         queue_reset_n_ff,
  output reg         two_wire_enable_ff,
  output reg         motion_detect_active_ff,
  output reg         motion_compare_mode_ff,
  output reg         accel_path_reset_ff,
  output reg         temp_path_reset_ff,
  output reg         gyro_path_reset_ff
);
  localparam ST_IDLE = 2'b01;
  localparam ST_ARMED = 2'b10;

  reg [15:0] temp_result_ff;
  reg [15:0] rate_x_result_ff;
  reg [15:0] rate_y_result_ff;
  reg [15:0] rate_z_result_ff;
  reg [7:0]  path_reset_control_ff;
  reg [7:0]  motion_detect_control_ff;
  reg [7:0]  host_control_ff;
  reg [1:0]  wom_state_ff;
  reg [1:0]  nxt_wom_state;
  reg [2:0]  tick_sync_ff;
  reg [7:0]  nxt_rdata;
  wire       slow_tick;
  wire       queue_rst_busy;
  wire       wr_path;
  wire       wr_motion;
  wire       wr_host;
  wire       all_reset;

  assign wr_path   = reg_wr && (reg_addr == `ADDR_PATH_RST);
  assign wr_motion = reg_wr && (reg_addr == `ADDR_MOTION_CTRL);
  assign wr_host   = reg_wr && (reg_addr == `ADDR_HOST_CTRL);
  assign all_reset = wr_host && reg_wdata[`BIT_ALL_RST];
  assign slow_tick = (tick_sync_ff[1] == tick_sync_ff[2]) && tick_sync_ff[1];

  // Internal oscillator tick is foreign to this clock
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_sync_ff <= 3'h0;
    end else begin
      tick_sync_ff <= {tick_sync_ff[1:0], osc_tick};
    end
  end

  pulse_stretch u_queue_rst (
    .clock     (clock),
    .nrst      (nrst),
    .start     (wr_host && reg_wdata[`BIT_QUEUE_RST]),
    .slow_tick (slow_tick),
    .busy_ff   (queue_rst_busy)
  );

  // Result capture; analog front end already applies 131 counts per dps
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      temp_result_ff   <= `RESET_WORD;
      rate_x_result_ff <= `RESET_WORD;
      rate_y_result_ff <= `RESET_WORD;
      rate_z_result_ff <= `RESET_WORD;
    end else if (all_reset) begin
      temp_result_ff   <= `RESET_WORD;
      rate_x_result_ff <= `RESET_WORD;
      rate_y_result_ff <= `RESET_WORD;
      rate_z_result_ff <= `RESET_WORD;
    end else if (sample_valid) begin
      temp_result_ff   <= temp_sample;
      rate_x_result_ff <= rate_x_sample;
      rate_y_result_ff <= rate_y_sample;
      rate_z_result_ff <= rate_z_sample;
    end
  end

  // Control registers; only defined bits are stored, except that motion control also stores its undefined bit 0
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      path_reset_control_ff    <= `RESET_BYTE;
      motion_detect_control_ff <= `RESET_BYTE;
      host_control_ff          <= `RESET_BYTE;
    end else begin
      if (wr_path) begin
        path_reset_control_ff <= reg_wdata & `MASK_PATH_RST;
      end else begin
        path_reset_control_ff <= `RESET_BYTE;
      end
      if (wr_motion) begin
        motion_detect_control_ff <= reg_wdata & `MASK_MOTION_CTRL;
      end
      if (wr_host) begin
        host_control_ff <= reg_wdata & `MASK_HOST_CTRL;
      end else begin
        host_control_ff[`BIT_ALL_RST] <= 1'b0;
        host_control_ff[`BIT_QUEUE_RST] <= queue_rst_busy && !slow_tick;
      end
    end
  end

  // Wake-on-motion arming: armed while motion control bit 7 is set; compare mode bit only passed out
  always @* begin
    nxt_wom_state = wom_state_ff;
    case (wom_state_ff)
      ST_IDLE: begin
        if (motion_detect_control_ff[`BIT_MOTION_EN]) begin
          nxt_wom_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!motion_detect_control_ff[`BIT_MOTION_EN]) begin
          nxt_wom_state = ST_IDLE;
        end
      end
      default: begin
        nxt_wom_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wom_state_ff <= ST_IDLE;
    end else begin
      wom_state_ff <= nxt_wom_state;
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      queue_write_ff          <= 1'b0;
      queue_host_access_ff    <= 1'b0;
      queue_reset_n_ff        <= 1'b1;
      two_wire_enable_ff      <= 1'b1;
      motion_detect_active_ff <= 1'b0;
      motion_compare_mode_ff  <= 1'b0;
      accel_path_reset_ff     <= 1'b0;
      temp_path_reset_ff      <= 1'b0;
      gyro_path_reset_ff      <= 1'b0;
    end else begin
      queue_write_ff          <= queue_src_write;
      queue_host_access_ff    <= host_control_ff[`BIT_QUEUE_EN];
      queue_reset_n_ff        <= !queue_rst_busy;
      two_wire_enable_ff      <= !host_control_ff[`BIT_TWO_WIRE_DIS];
      motion_detect_active_ff <= (wom_state_ff == ST_ARMED);
      motion_compare_mode_ff  <= motion_detect_control_ff[`BIT_MOTION_MODE];
      accel_path_reset_ff     <= path_reset_control_ff[`BIT_ACCEL_RST] ||
                                 host_control_ff[`BIT_ALL_RST];
      temp_path_reset_ff      <= path_reset_control_ff[`BIT_TEMP_RST] ||
                                 host_control_ff[`BIT_ALL_RST];
      gyro_path_reset_ff      <= host_control_ff[`BIT_ALL_RST];
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    nxt_rdata = `RESET_BYTE;
    case (reg_addr)
      `ADDR_TEMP_H:      nxt_rdata = temp_result_ff[15:8];
      `ADDR_TEMP_L:      nxt_rdata = temp_result_ff[7:0];
      `ADDR_RATE_X_H:    nxt_rdata = rate_x_result_ff[15:8];
      `ADDR_RATE_X_L:    nxt_rdata = rate_x_result_ff[7:0];
      `ADDR_RATE_Y_H:    nxt_rdata = rate_y_result_ff[15:8];
      `ADDR_RATE_Y_L:    nxt_rdata = rate_y_result_ff[7:0];
      `ADDR_RATE_Z_H:    nxt_rdata = rate_z_result_ff[15:8];
      `ADDR_RATE_Z_L:    nxt_rdata = rate_z_result_ff[7:0];
      `ADDR_PATH_RST:    nxt_rdata = path_reset_control_ff;
      `ADDR_MOTION_CTRL: nxt_rdata = motion_detect_control_ff;
      `ADDR_HOST_CTRL:   nxt_rdata = host_control_ff;
      default:           nxt_rdata = `RESET_BYTE;
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_ff <= `RESET_BYTE;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end
endmodule

// ### src/sensor_regs_consts.vh
`ifndef SENSOR_REGS_CONSTS_VH
`define SENSOR_REGS_CONSTS_VH
`define ADDR_TEMP_H       8'h41
`define ADDR_TEMP_L       8'h42
`define ADDR_RATE_X_H     8'h43
`define ADDR_RATE_X_L     8'h44
`define ADDR_RATE_Y_H     8'h45
`define ADDR_RATE_Y_L     8'h46
`define ADDR_RATE_Z_H     8'h47
`define ADDR_RATE_Z_L     8'h48
`define ADDR_PATH_RST     8'h68
`define ADDR_MOTION_CTRL  8'h69
`define ADDR_HOST_CTRL    8'h6a
`define BIT_ACCEL_RST     1
`define BIT_TEMP_RST      0
`define BIT_MOTION_EN     7
`define BIT_MOTION_MODE   6
`define BIT_QUEUE_EN      6
`define BIT_TWO_WIRE_DIS  4
`define BIT_QUEUE_RST     2
`define BIT_ALL_RST       0
`define MASK_PATH_RST     8'h03
`define MASK_MOTION_CTRL  8'hc1
`define MASK_HOST_CTRL    8'h55
`define RESET_BYTE        8'h00
`define RESET_WORD        16'h0000
`define GYRO_SENS_FS0     16'd131
`endif
